// ---- rtl/cfg_regs_consts.svh ----
`ifndef CFG_REGS_CONSTS_SVH
`define CFG_REGS_CONSTS_SVH

// register byte offsets on the configuration port
`define ADDR_STAMP_CTRL    15'h003b
`define ADDR_REFOUT_CTRL   15'h003c
`define ADDR_FBDIV_VP      15'h003d
`define ADDR_FBDIV_N       15'h003e
`define ADDR_OSC_BIAS      15'h003f
`define ADDR_EMPHASIS      15'h0048

// reset values
`define RST_STAMP_CTRL     8'h00
`define RST_REFOUT_CTRL    8'h01
`define RST_FBDIV_VP       8'h00
`define RST_FBDIV_N        8'h20
`define RST_OSC_BIAS       8'h4f
`define RST_EMPHASIS       8'h00
`define RD_UNMAPPED        8'h00

// field positions
`define BIT_STAMP_RECV     0
`define BIT_STAMP_LOWVOLT  1
`define BIT_REFOUT_EN      0
`define FLD_P_DIV          3:2
`define FLD_V_DIV          1:0
`define FLD_N_DIV          5:0
`define FLD_OSC_BIAS       6:0
`define FLD_EMPHASIS       3:0

// divider codes and ratios
`define DIV_CODE_0         2'h0
`define DIV_CODE_1         2'h1
`define DIV_CODE_2         2'h2
`define P_RATIO_0          3'h1
`define P_RATIO_1          3'h2
`define P_RATIO_2          3'h4
`define V_RATIO_0          3'h5
`define V_RATIO_1          3'h4
`define V_RATIO_2          3'h3
`define RATIO_RESERVED     3'h0

`endif

// ---- rtl/cfg_regs_pkg.sv ----
package cfg_regs_pkg;

	typedef logic [7:0]  reg_byte_t;
	typedef logic [14:0] reg_addr_t;
	typedef logic [2:0]  div_ratio_t;

	// register selected by an address
	typedef enum logic [2:0] {
		SEL_NONE     = 3'b000,
		SEL_STAMP    = 3'b001,
		SEL_REFOUT   = 3'b010,
		SEL_FBDIV_VP = 3'b011,
		SEL_FBDIV_N  = 3'b100,
		SEL_OSC_BIAS = 3'b101,
		SEL_EMPHASIS = 3'b110
	} reg_sel_e;

endpackage

// ---- rtl/level_sync.sv ----
`timescale 1ns/100ps
`default_nettype none

module level_sync (
	input  wire logic ref_clk,
	input  wire logic resetn,
	input  wire logic async_in,
	output logic      sync_out
);

	logic meta_ff;
	logic nxt_meta;
	logic sync_ff;
	logic nxt_sync;

	// first stage feeds only the second stage
	always_comb begin
		nxt_meta = async_in;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign sync_out = sync_ff;

endmodule

`default_nettype wire

// ---- rtl/pll_timestamp_serdes_config_regs.sv ----
// How it works
// R01: software rewrites reserved fields with reset values
// R02: stamp bit 1 selects low-voltage receive mode
// R03: stamp bit 0 enables receiver, reset off
// R04: reference output driven when enabled and pll on
// R05: reference enable bit resets to one
// R06: bits 3:2 pick second divider 1/2/4
// R07: bits 1:0 pick first divider 5/4/3
// R08: software resets pll before changing dividers; host model raises synth_reset in the same cycle as the divider write
// R09: third divider holds ratio directly, resets 32
// R10: third divider yields detector feedback clock ratio
// R11: software programs oscillator bias to 0x4a
// R12: one emphasis setting drives all eight lanes
// R13: fields read back last written or reset
`timescale 1ns/100ps
`default_nettype none
`include "cfg_regs_consts.svh"

module pll_timestamp_serdes_config_regs
	import cfg_regs_pkg::*;
#(
	parameter int LANES = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             resetn,
	input  wire logic             wr_en,
	input  wire logic             rd_en,
	input  wire logic [14:0]      addr,
	input  wire logic [7:0]       wr_data,
	input  wire logic             pll_enable,
	output logic      [7:0]       rd_data,
	output logic                  rd_valid,
	output logic                  stamp_receiver_en,
	output logic                  stamp_lowvolt_mode_en,
	output logic                  ref_clock_output_on,
	output logic      [2:0]       p_div_ratio,
	output logic      [2:0]       v_div_ratio,
	output logic      [5:0]       n_div_ratio,
	output logic      [6:0]       oscillator_bias,
	output logic      [LANES*4-1:0] lane_emphasis
);

	// address decode, shared by reads and writes
	function automatic reg_sel_e decode(input reg_addr_t a);
		unique case (a)
			`ADDR_STAMP_CTRL:  decode = SEL_STAMP;
			`ADDR_REFOUT_CTRL: decode = SEL_REFOUT;
			`ADDR_FBDIV_VP:    decode = SEL_FBDIV_VP;
			`ADDR_FBDIV_N:     decode = SEL_FBDIV_N;
			`ADDR_OSC_BIAS:    decode = SEL_OSC_BIAS;
			`ADDR_EMPHASIS:    decode = SEL_EMPHASIS;
			default:           decode = SEL_NONE;
		endcase
	endfunction

	// second divider code to ratio, code 3 gives zero
	function automatic div_ratio_t p_ratio(input logic [1:0] c);
		unique case (c)
			`DIV_CODE_0: p_ratio = `P_RATIO_0;
			`DIV_CODE_1: p_ratio = `P_RATIO_1;
			`DIV_CODE_2: p_ratio = `P_RATIO_2;
			default:     p_ratio = `RATIO_RESERVED;
		endcase
	endfunction

	// first divider code to ratio, code 3 gives zero
	function automatic div_ratio_t v_ratio(input logic [1:0] c);
		unique case (c)
			`DIV_CODE_0: v_ratio = `V_RATIO_0;
			`DIV_CODE_1: v_ratio = `V_RATIO_1;
			`DIV_CODE_2: v_ratio = `V_RATIO_2;
			default:     v_ratio = `RATIO_RESERVED;
		endcase
	endfunction

	reg_sel_e  wr_sel;
	reg_sel_e  rd_sel;
	logic      pll_en_sync;
	reg_byte_t stamp_ff,  nxt_stamp;
	reg_byte_t refout_ff, nxt_refout;
	reg_byte_t vp_ff,     nxt_vp;
	reg_byte_t n_ff,      nxt_n;
	reg_byte_t bias_ff,   nxt_bias;
	reg_byte_t emph_ff,   nxt_emph;
	reg_byte_t rd_data_ff, nxt_rd_data;
	logic      rd_valid_ff, nxt_rd_valid;
	logic      recv_ff, nxt_recv;
	logic      lowv_ff, nxt_lowv;
	logic      refon_ff, nxt_refon;
	logic [2:0] p_ff, nxt_p;
	logic [2:0] v_ff, nxt_v;
	logic [5:0] ndiv_ff, nxt_ndiv;
	logic [6:0] osc_ff, nxt_osc;
	logic [3:0] emph_out_ff, nxt_emph_out;

	// pll enable pin into the clock domain
	level_sync u_pll_en_sync (
		.ref_clk  (ref_clk),
		.resetn   (resetn),
		.async_in (pll_enable),
		.sync_out (pll_en_sync)
	);

	assign wr_sel = decode(addr);
	assign rd_sel = decode(addr);

	// register writes; reserved bits stored as written
	always_comb begin
		nxt_stamp  = stamp_ff;
		nxt_refout = refout_ff;
		nxt_vp     = vp_ff;
		nxt_n      = n_ff;
		nxt_bias   = bias_ff;
		nxt_emph   = emph_ff;
		if (wr_en) begin
			unique case (wr_sel)
				SEL_STAMP:    nxt_stamp  = wr_data; // R13
				SEL_REFOUT:   nxt_refout = wr_data;
				SEL_FBDIV_VP: nxt_vp     = wr_data;
				SEL_FBDIV_N:  nxt_n      = wr_data;
				SEL_OSC_BIAS: nxt_bias   = wr_data;
				SEL_EMPHASIS: nxt_emph   = wr_data;
				SEL_NONE:     nxt_stamp  = stamp_ff;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			stamp_ff  <= `RST_STAMP_CTRL; // R03
			refout_ff <= `RST_REFOUT_CTRL; // R05
			vp_ff     <= `RST_FBDIV_VP;
			n_ff      <= `RST_FBDIV_N; // R09
			bias_ff   <= `RST_OSC_BIAS;
			emph_ff   <= `RST_EMPHASIS;
		end else begin
			stamp_ff  <= nxt_stamp;
			refout_ff <= nxt_refout;
			vp_ff     <= nxt_vp;
			n_ff      <= nxt_n;
			bias_ff   <= nxt_bias;
			emph_ff   <= nxt_emph;
		end
	end

	// read path, answer one cycle after rd_en
	always_comb begin
		nxt_rd_valid = rd_en;
		nxt_rd_data  = rd_data_ff;
		if (rd_en) begin
			unique case (rd_sel)
				SEL_STAMP:    nxt_rd_data = stamp_ff; // R13
				SEL_REFOUT:   nxt_rd_data = refout_ff;
				SEL_FBDIV_VP: nxt_rd_data = vp_ff;
				SEL_FBDIV_N:  nxt_rd_data = n_ff;
				SEL_OSC_BIAS: nxt_rd_data = bias_ff;
				SEL_EMPHASIS: nxt_rd_data = emph_ff;
				SEL_NONE:     nxt_rd_data = `RD_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			rd_data_ff  <= `RD_UNMAPPED;
			rd_valid_ff <= 1'b0;
		end else begin
			rd_data_ff  <= nxt_rd_data;
			rd_valid_ff <= nxt_rd_valid;
		end
	end

	// control outputs follow the new register values
	always_comb begin
		nxt_recv     = nxt_stamp[`BIT_STAMP_RECV]; // R03
		nxt_lowv     = nxt_stamp[`BIT_STAMP_LOWVOLT]; // R02
		nxt_refon    = nxt_refout[`BIT_REFOUT_EN] & pll_en_sync; // R04
		nxt_p        = p_ratio(nxt_vp[`FLD_P_DIV]); // R06
		nxt_v        = v_ratio(nxt_vp[`FLD_V_DIV]); // R07
		nxt_ndiv     = nxt_n[`FLD_N_DIV]; // R10
		nxt_osc      = nxt_bias[`FLD_OSC_BIAS];
		nxt_emph_out = nxt_emph[`FLD_EMPHASIS]; // R12
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			recv_ff     <= 1'(`RST_STAMP_CTRL >> `BIT_STAMP_RECV); // R03
			lowv_ff     <= 1'(`RST_STAMP_CTRL >> `BIT_STAMP_LOWVOLT);
			refon_ff    <= 1'b0; // synchroniser is cleared too
			p_ff        <= `P_RATIO_0;
			v_ff        <= `V_RATIO_0;
			ndiv_ff     <= 6'(`RST_FBDIV_N); // R09
			osc_ff      <= 7'(`RST_OSC_BIAS);
			emph_out_ff <= 4'(`RST_EMPHASIS);
		end else begin
			recv_ff     <= nxt_recv;
			lowv_ff     <= nxt_lowv;
			refon_ff    <= nxt_refon;
			p_ff        <= nxt_p;
			v_ff        <= nxt_v;
			ndiv_ff     <= nxt_ndiv;
			osc_ff      <= nxt_osc;
			emph_out_ff <= nxt_emph_out;
		end
	end

	assign rd_data               = rd_data_ff;
	assign rd_valid              = rd_valid_ff;
	assign stamp_receiver_en     = recv_ff;
	assign stamp_lowvolt_mode_en = lowv_ff;
	assign ref_clock_output_on   = refon_ff;
	assign p_div_ratio           = p_ff;
	assign v_div_ratio           = v_ff;
	assign n_div_ratio           = ndiv_ff;
	assign oscillator_bias       = osc_ff;

	// same emphasis copied onto every lane
	genvar gi;
	generate
		for (gi = 0; gi < LANES; gi++) begin : g_lane
			assign lane_emphasis[gi*4 +: 4] = emph_out_ff; // R12
		end
	endgenerate

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	property p_lowvolt;
		wr_en && addr == `ADDR_STAMP_CTRL |=> stamp_lowvolt_mode_en == $past(wr_data[1]);
	endproperty
	a_lowvolt: assert property (p_lowvolt) else $error("low-voltage mode bit wrong"); // R02

	property p_recv;
		wr_en && addr == `ADDR_STAMP_CTRL |=> stamp_receiver_en == $past(wr_data[0]);
	endproperty
	a_recv: assert property (p_recv) else $error("receiver enable wrong"); // R03

	property p_refon;
		ref_clock_output_on == (refout_ff[`BIT_REFOUT_EN] && $past(pll_en_sync));
	endproperty
	a_refon: assert property (p_refon) else $error("reference output on without cause"); // R04

	property p_reset_vals;
		$rose(resetn) |-> refout_ff == `RST_REFOUT_CTRL && n_ff == `RST_FBDIV_N
			&& bias_ff == `RST_OSC_BIAS;
	endproperty
	a_reset_vals: assert property (@(posedge ref_clk) p_reset_vals) else $error("bad reset value"); // R05

	property p_pdiv;
		wr_en && addr == `ADDR_FBDIV_VP && wr_data[3:2] == 2'h2 |=> p_div_ratio == 3'h4;
	endproperty
	a_pdiv: assert property (p_pdiv) else $error("second divider ratio wrong"); // R06

	property p_vdiv;
		wr_en && addr == `ADDR_FBDIV_VP && wr_data[1:0] == 2'h0 |=> v_div_ratio == 3'h5;
	endproperty
	a_vdiv: assert property (p_vdiv) else $error("first divider ratio wrong"); // R07

	property p_ndiv;
		wr_en && addr == `ADDR_FBDIV_N ##1 !(wr_en && addr == `ADDR_FBDIV_N) [*2]
			|-> n_div_ratio == $past(wr_data[5:0], 2);
	endproperty
	a_ndiv: assert property (p_ndiv) else $error("third divider not held"); // R09

	property p_lanes;
		lane_emphasis[3:0] == lane_emphasis[LANES*4-1 -: 4] && lane_emphasis[3:0] == emph_ff[3:0];
	endproperty
	a_lanes: assert property (p_lanes) else $error("lanes disagree on emphasis"); // R12

	property p_readback;
		wr_en && addr == `ADDR_OSC_BIAS ##1 rd_en && !wr_en && addr == `ADDR_OSC_BIAS
			|=> rd_valid && rd_data == $past(wr_data, 2);
	endproperty
	a_readback: assert property (p_readback) else $error("read-back mismatch"); // R13

	c_refon:  cover property (pll_en_sync ##1 ref_clock_output_on);
	c_pres:   cover property (wr_en && addr == `ADDR_FBDIV_VP && wr_data[3:2] == 2'h3);
	c_unmap:  cover property (rd_en && rd_sel == SEL_NONE);
	c_bias:   cover property (wr_en && addr == `ADDR_OSC_BIAS && wr_data == 8'h4a);
	c_same:   cover property (wr_en && rd_en && addr == `ADDR_OSC_BIAS);

endmodule

`default_nettype wire

// ---- verification/cfg_host.sv ----
`timescale 1ns/100ps
`default_nettype none

module cfg_host (
	input  wire logic        ref_clk,
	output logic             wr_en,
	output logic             rd_en,
	output logic      [14:0] addr,
	output logic      [7:0]  wr_data
);
	logic synth_reset; // model of the pll reset bit, raised in the same cycle as each divider write

	// idle port at time zero
	initial begin
		synth_reset = 1'b0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 15'h0000;
		wr_data = 8'h00;
	end

	// field bits software may set; reserved bits reset to zero
	function automatic logic [7:0] keep(input logic [14:0] a);
		case (a)
			15'h003b: keep = 8'h03;
			15'h003c: keep = 8'h01;
			15'h003e: keep = 8'h3f;
			15'h003f: keep = 8'h7f;
			default:  keep = 8'h0f;
		endcase
	endfunction

	// value software writes: reserved bits back to reset, bias fixed
	function automatic logic [7:0] fix(input logic [14:0] a, input logic [7:0] d);
		fix = d & keep(a);
		if (a == 15'h003f)
			fix = 8'h4a;
	endfunction

	// one write; released lines show inverted values
	task automatic wr(input logic [14:0] a, input logic [7:0] d, output logic [7:0] s);
		s = fix(a, d);
		@(negedge ref_clk);
		synth_reset = (a == 15'h003d || a == 15'h003e);
		wr_en = 1'b1;
		addr = a;
		wr_data = s;
		@(negedge ref_clk);
		synth_reset = 1'b0;
		wr_en = 1'b0;
		addr = ~a;
		wr_data = ~s;
	endtask

	// write and read in one cycle, then read the new value
	task automatic wr_rd(input logic [14:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		synth_reset = (a == 15'h003d || a == 15'h003e);
		wr_en = 1'b1;
		rd_en = 1'b1;
		addr = a;
		wr_data = fix(a, d);
		@(negedge ref_clk);
		wr_en = 1'b0;
		wr_data = ~wr_data;
		@(negedge ref_clk);
		synth_reset = 1'b0;
		rd_en = 1'b0;
		addr = ~a;
	endtask

	// one read request
	task automatic rd(input logic [14:0] a);
		@(negedge ref_clk);
		rd_en = 1'b1;
		addr = a;
		@(negedge ref_clk);
		rd_en = 1'b0;
		addr = ~a;
	endtask
endmodule

`default_nettype wire

// ---- verification/pll_timestamp_serdes_config_regs_test.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "cfg_regs_consts.svh"

module pll_timestamp_serdes_config_regs_test import cfg_regs_pkg::*;;
	logic        ref_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        pll_enable = 1'b1;
	logic        wr_en, rd_en, rd_valid, recv, lowv, refon;
	logic [14:0] addr;
	logic [7:0]  wr_data, rd_data, s;
	logic [2:0]  p, v;
	logic [5:0]  n;
	logic [6:0]  bias;
	logic [31:0] emph, seed = 32'h5f52; // starts at 24402
	int          err_count = 0, cmp_count = 0, cyc = 0, j;
	reg_byte_t   q[$];
	reg_byte_t   sh[6];
	reg_byte_t   rv[6] = '{8'h00, 8'h01, 8'h00, 8'h20, 8'h4f, 8'h00};
	reg_addr_t   ad[6] = '{`ADDR_STAMP_CTRL, `ADDR_REFOUT_CTRL, `ADDR_FBDIV_VP,
		`ADDR_FBDIV_N, `ADDR_OSC_BIAS, `ADDR_EMPHASIS};
	logic [2:0]  pr[4] = '{3'h1, 3'h2, 3'h4, 3'h0};
	logic [2:0]  vr[4] = '{3'h5, 3'h4, 3'h3, 3'h0};

	// clock, 100 ns period
	always #50 ref_clk = ~ref_clk;

	cfg_host h (.ref_clk(ref_clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wr_data(wr_data));

	pll_timestamp_serdes_config_regs uut (.ref_clk(ref_clk), .resetn(resetn),
		.wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
		.pll_enable(pll_enable), .rd_data(rd_data), .rd_valid(rd_valid),
		.stamp_receiver_en(recv), .stamp_lowvolt_mode_en(lowv),
		.ref_clock_output_on(refon), .p_div_ratio(p), .v_div_ratio(v),
		.n_div_ratio(n), .oscillator_bias(bias), .lane_emphasis(emph));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	// read with its expected answer noted first
	task automatic rd_chk(input reg_addr_t a, input reg_byte_t e);
		q.push_back(e);
		h.rd(a);
	endtask

	// control outputs against the shadow copy
	task automatic outs();
		chk(recv, sh[0][0]);
		chk(lowv, sh[0][1]);
		chk(refon, sh[1][0] & pll_enable);
		chk(p, pr[sh[2][3:2]]);
		chk(v, vr[sh[2][1:0]]);
		chk(n, sh[3][5:0]);
		chk(bias, sh[4][6:0]);
		chk(emph, {8{sh[5][3:0]}});
	endtask

	task automatic do_reset();
		resetn = 1'b0;
		repeat (4) @(negedge ref_clk);
		resetn = 1'b1;
		sh = rv;
	endtask

	// read answers taken off the queue
	always @(negedge ref_clk) begin
		if (rd_valid === 1'b1) begin
			if (q.size() == 0)
				chk(rd_valid, 1'b0);
			else
				chk(rd_data, q.pop_front());
		end
	end

	// hang limit
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 4000) begin
			err_count++;
			$display("unexpected at %0t: timeout", $time);
			give_verdict();
		end
	end

	initial begin
		do_reset();
		for (int i = 0; i < 6; i++) rd_chk(ad[i], rv[i]);
		outs();
		$display("test reset_values done");
		for (int i = 0; i < 16; i++) begin
			h.wr(`ADDR_FBDIV_VP, 8'(i), sh[2]);
			@(negedge ref_clk);
			outs();
			rd_chk(`ADDR_FBDIV_VP, sh[2]);
		end
		$display("test divider_codes done");
		for (int k = 0; k < 30; k++) begin
			seed = xs(seed);
			j = int'(seed % 6);
			h.wr(ad[j], seed[15:8], sh[j]);
			@(negedge ref_clk);
			outs();
			rd_chk(ad[j], sh[j]);
		end
		$display("test random_writes done");
		// write and read of one register in one cycle: old value first
		for (int k = 0; k < 6; k++) begin
			seed = xs(seed);
			q.push_back(sh[k]);
			sh[k] = h.fix(ad[k], seed[7:0]);
			q.push_back(sh[k]);
			h.wr_rd(ad[k], seed[7:0]);
		end
		@(negedge ref_clk);
		outs();
		$display("test same_cycle_access done");
		h.wr(`ADDR_REFOUT_CTRL, 8'h01, sh[1]);
		pll_enable = 1'b0;
		repeat (4) @(negedge ref_clk);
		chk(refon, 1'b0);
		pll_enable = 1'b1;
		repeat (4) @(negedge ref_clk);
		chk(refon, 1'b1);
		$display("test ref_output done");
		h.wr(15'h0040, 8'h0f, s);
		rd_chk(15'h0040, 8'h00);
		outs();
		$display("test unmapped done");
		do_reset();
		repeat (3) @(negedge ref_clk);
		outs();
		chk(q.size(), 0);
		$display("test second_reset done");
		give_verdict();
	end
endmodule

`default_nettype wire
